// ==== rtl/serial_port_pkg.sv ====
// constants shared by the four-mode serial port and its helpers
// assumes a single 100 MHz pclk domain and an active-low async reset
package serial_port_pkg;

  // register indices; byte address on the bus is four times the index
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_POWER = 8'h87;
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] IDX_IE = 8'hA8;
  localparam logic [7:0] IDX_IP = 8'hB8;
  localparam logic [7:0] REG_RESET = 8'h00;

  // serial_control bit positions
  localparam int SC_RI = 0;
  localparam int SC_TI = 1;
  localparam int SC_RB8 = 2;
  localparam int SC_TB8 = 3;
  localparam int SC_REN = 4;
  localparam int SC_SM2 = 5;

  // power_control, interrupt_enable, interrupt_priority fields
  localparam int PC_RATE2 = 7;
  localparam int IE_ES = 4;
  localparam int IE_EA = 7;
  localparam int IP_PS = 4;
  localparam logic [7:0] PC_MASK = 8'hD0;
  localparam logic [7:0] IE_MASK = 8'hBF;
  localparam logic [7:0] IP_MASK = 8'h3F;

  // dividers: mode 0 bit period, mode 2 oversample (64/16 and 32/16)
  localparam int M0_DIV = 12;
  localparam int M2_SLOW_OS_DIV = 4;
  localparam int M2_FAST_OS_DIV = 2;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] LAST_M0 = 4'h7;
  localparam logic [3:0] LAST_M1 = 4'h9;
  localparam logic [3:0] LAST_M23 = 4'hA;

  // interrupt identity as seen by the interrupt controller
  localparam logic [7:0] IRQ_VECTOR = 8'h23;
  localparam int IRQ_NATURAL_PRIO = 5;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9_FIXED = 2'b10,
    MODE_UART9_VAR = 2'b11
  } mode_type;

endpackage

// ==== rtl/rate_tick.sv ====
// free-running divider giving a one-cycle tick every DIV clocks
// assumes DIV is at least 2; high marks the second half of the period
`timescale 1ns/1ps
module rate_tick
  import serial_port_pkg::*;
#(
  parameter int DIV = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick,
  output logic high
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] HALF = W'(DIV / 2);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // wrap at the end of each period
  always_comb begin
    tick = (cnt_r == LAST);
    high = (cnt_r >= HALF);
    cnt_nxt = tick ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    tick |=> !tick) else $error("divider tick repeated");
endmodule // rate_tick

// ==== rtl/serial_tx.sv ====
// transmit shifter for all four modes; line is unregistered
// assumes the caller registers the pins and starts only when idle
`timescale 1ns/1ps
module serial_tx
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic ninth,
  input wire mode_type mode,
  input wire logic os_tick,
  input wire logic m0_tick,
  output logic line,
  output logic busy,
  output logic shifting,
  output logic done
);
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ALIGN = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_type;
  tx_state_type state_r, state_nxt;
  logic [10:0] frame_r, frame_nxt;
  logic [3:0] pos_r, pos_nxt;
  logic [3:0] sub_r, sub_nxt;
  logic tick;
  logic m0;
  logic [3:0] last_pos;

  // frame sequencing; mode 0 moves one bit per tick, others per 16
  always_comb begin
    m0 = (mode == MODE_SHIFT);
    tick = m0 ? m0_tick : os_tick;
    last_pos = m0 ? LAST_M0 : (mode == MODE_UART8) ? LAST_M1 : LAST_M23;
    state_nxt = state_r;
    frame_nxt = frame_r;
    pos_nxt = pos_r;
    sub_nxt = sub_r;
    done = 1'b0;
    case (state_r)
      TX_IDLE: begin
        if (start) begin
          // start, data lsb first, ninth or stop, stop
          frame_nxt = m0 ? {3'b111, data} :
            {1'b1, (mode == MODE_UART8) ? 1'b1 : ninth, data, 1'b0};
          state_nxt = TX_ALIGN;
        end
      end
      TX_ALIGN: begin
        // wait for a period boundary so the first bit is full length
        if (tick) begin
          state_nxt = TX_SHIFT;
          pos_nxt = 4'h0;
          sub_nxt = 4'h0;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          if (m0 || sub_r == OS_LAST) begin
            sub_nxt = 4'h0;
            frame_nxt = {1'b1, frame_r[10:1]};
            pos_nxt = pos_r + 4'h1;
            if (pos_r == last_pos) begin
              done = 1'b1;
              state_nxt = TX_IDLE;
            end
          end else begin
            sub_nxt = sub_r + 4'h1;
          end
        end
      end
      default: state_nxt = TX_IDLE;
    endcase
    line = (state_r == TX_SHIFT) ? frame_r[0] : 1'b1;
    busy = (state_r != TX_IDLE);
    shifting = (state_r == TX_SHIFT);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TX_IDLE;
      frame_r <= 11'h7FF;
      pos_r <= 4'h0;
      sub_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      frame_r <= frame_nxt;
      pos_r <= pos_nxt;
      sub_r <= sub_nxt;
    end
  end

  a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == TX_ALIGN && tick && !m0) |=> !line)
    else $error("async frame did not open with a low start bit");
endmodule // serial_tx

// ==== rtl/serial_port.sv ====
// four-mode serial port with its control registers on APB
// assumes timer overflow pulses are one pclk wide and act as 16x ticks
//
// What this block does
// - Transmit and receive run together in modes 1-3; mode 0 reception waits for the transmitter to be idle. Received byte held apart from shifter.
// - Buffer read returns receive holding; buffer write loads transmitter, starts.
// - Two mode bits pick shift, 8-bit async, 9-bit fixed, 9-bit variable.
// - Mode 2 rate is clock/64, or clock/32 with rate-double set.
// - Modes 1 and 3 run from the selected timer overflow pulses.
// - With filter set in modes 2,3 only ninth bit 1 raises receive flag.
// - Reception only while receive-enable is 1; clearing it stops reception.
// - Modes 2 and 3 send the tx ninth bit as ninth data bit.
// - Rx ninth bit: ninth bit in modes 2,3; stop bit in mode 1.
// - Transmit-done flag set by hardware at end of frame, cleared by software.
// - Receive-done flag set by hardware at end of frame, cleared by software.
// - Software writes to the flags act exactly like hardware updates.
// - Interrupt when either flag set, gated by serial and global enables.
// - Mode 0: transmit pin is clock/12 shift clock, data pin, LSB first.
// - Mode 0 reception starts when receive flag is 0 and enable is 1.
// - Mode 1 frame: start 0, eight data LSB first, stop 1.
// - Modes 2,3 frame: start, eight data, ninth bit, stop.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module serial_port
  import serial_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic tx_timer2_sel,
  input wire logic rx_timer2_sel,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe_n,
  output logic txd,
  output logic serial_irq,
  output logic serial_irq_high
);
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b011,
    RX_M0_ALIGN = 3'b100,
    RX_M0_SHIFT = 3'b101
  } rx_state_type;

  logic [7:0] serial_control_r, serial_control_nxt;
  logic [7:0] power_control_r, power_control_nxt;
  logic [7:0] ie_r, ie_nxt;
  logic [7:0] ip_r, ip_nxt;
  logic [7:0] rx_hold_r, rx_hold_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic txd_r, txd_nxt;
  logic rxd_out_r, rxd_out_nxt;
  logic rxd_oe_n_r, rxd_oe_n_nxt;
  logic irq_r, irq_nxt;
  logic irq_high_r, irq_high_nxt;
  rx_state_type rx_state_r, rx_state_nxt;
  logic [3:0] rx_sub_r, rx_sub_nxt;
  logic [3:0] rx_pos_r, rx_pos_nxt;
  logic [8:0] rx_shift_r, rx_shift_nxt;
  logic rxd_prev_r;

  mode_type mode;
  logic m0;
  logic setup, wr;
  logic sel_pc, sel_serial_control, sel_serial_buffer, sel_ie, sel_ip;
  logic [7:0] rd_byte;
  logic m0_tick, m0_high, os_slow, os_fast, m2_os;
  logic tx_os, rx_os, rx_tick;
  logic tx_start, tx_line, tx_busy, tx_shifting, tx_done;
  logic rx_done, rx_accept, rx_ninth, rx_m0_active;

  //////////////////////////////////////////////////////////////////////
  // rate sources

  rate_tick #(.DIV(M0_DIV)) u_m0_rate (
    .pclk(pclk),
    .presetn(presetn),
    .tick(m0_tick),
    .high(m0_high)
  );

  rate_tick #(.DIV(M2_SLOW_OS_DIV)) u_m2_slow (
    .pclk(pclk),
    .presetn(presetn),
    .tick(os_slow),
    .high()
  );

  rate_tick #(.DIV(M2_FAST_OS_DIV)) u_m2_fast (
    .pclk(pclk),
    .presetn(presetn),
    .tick(os_fast),
    .high()
  );

  // oversample tick per direction; rx and tx may use different timers
  always_comb begin
    mode = mode_type'(serial_control_r[7:6]);
    m0 = (mode == MODE_SHIFT);
    m2_os = power_control_r[PC_RATE2] ? os_fast : os_slow;
    tx_os = (mode == MODE_UART9_FIXED) ? m2_os :
      (tx_timer2_sel ? timer2_ovf : timer1_ovf);
    rx_os = (mode == MODE_UART9_FIXED) ? m2_os :
      (rx_timer2_sel ? timer2_ovf : timer1_ovf);
  end

  //////////////////////////////////////////////////////////////////////
  // transmitter, independent of the receive path

  serial_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .start(tx_start),
    .data(pwdata[7:0]),
    .ninth(serial_control_r[SC_TB8]),
    .mode(mode),
    .os_tick(tx_os),
    .m0_tick(m0_tick),
    .line(tx_line),
    .busy(tx_busy),
    .shifting(tx_shifting),
    .done(tx_done)
  );

  //////////////////////////////////////////////////////////////////////
  // APB decode; no wait states, read data comes from a flop loaded in setup

  always_comb begin
    setup = psel && !penable;
    wr = psel && penable && pready_r && pwrite;
    sel_pc = (paddr[ADDR_W-1:2] == {2'b00, IDX_POWER});
    sel_serial_control = (paddr[ADDR_W-1:2] == {2'b00, IDX_SERIAL_CONTROL});
    sel_serial_buffer = (paddr[ADDR_W-1:2] == {2'b00, IDX_SERIAL_BUFFER});
    sel_ie = (paddr[ADDR_W-1:2] == {2'b00, IDX_IE});
    sel_ip = (paddr[ADDR_W-1:2] == {2'b00, IDX_IP});
    rd_byte = 8'h00;
    if (sel_pc) rd_byte = power_control_r;
    if (sel_serial_control) rd_byte = serial_control_r;
    if (sel_serial_buffer) rd_byte = rx_hold_r;
    if (sel_ie) rd_byte = ie_r;
    if (sel_ip) rd_byte = ip_r;
    prdata_nxt = setup ? {24'h000000, rd_byte} : prdata_r;
    pready_nxt = setup;
    pslverr_nxt = setup &&
      !(sel_pc || sel_serial_control || sel_serial_buffer || sel_ie || sel_ip);
    // a write while a frame is still going is dropped, not restarted
    tx_start = wr && sel_serial_buffer && !tx_busy;
  end

  //////////////////////////////////////////////////////////////////////
  // receiver: 16x async sampler and mode 0 clocked shifter

  always_comb begin
    rx_m0_active = (rx_state_r == RX_M0_SHIFT);
    rx_tick = rx_os;
    rx_state_nxt = rx_state_r;
    rx_sub_nxt = rx_sub_r;
    rx_pos_nxt = rx_pos_r;
    rx_shift_nxt = rx_shift_r;
    rx_done = 1'b0;
    case (rx_state_r)
      RX_IDLE: begin
        if (m0) begin
          // shift-mode reception waits for an empty flag
          if (serial_control_r[SC_REN] && !serial_control_r[SC_RI] && !tx_busy)
            rx_state_nxt = RX_M0_ALIGN;
        end else if (serial_control_r[SC_REN] && rxd_prev_r && !rxd_in) begin
          rx_state_nxt = RX_START; // falling start edge
          rx_sub_nxt = 4'h0;
        end
      end
      RX_START: begin
        if (rx_tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == OS_MID) begin
            // a start that is high at its centre was a glitch
            rx_state_nxt = rxd_in ? RX_IDLE : RX_DATA;
            rx_sub_nxt = 4'h0;
            rx_pos_nxt = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (rx_tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == OS_LAST) begin
            rx_shift_nxt = {rxd_in, rx_shift_r[8:1]};
            rx_pos_nxt = rx_pos_r + 4'h1;
            if (rx_pos_r == ((mode == MODE_UART8) ? 4'h7 : 4'h8))
              rx_state_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_tick) begin
          rx_sub_nxt = rx_sub_r + 4'h1;
          if (rx_sub_r == OS_LAST) begin
            rx_done = 1'b1;
            rx_state_nxt = RX_IDLE;
          end
        end
      end
      RX_M0_ALIGN: begin
        if (m0_tick) begin
          rx_state_nxt = RX_M0_SHIFT;
          rx_pos_nxt = 4'h0;
        end
      end
      RX_M0_SHIFT: begin
        // sample at the end of the high half of the shift clock
        if (m0_tick) begin
          rx_shift_nxt = {rxd_in, rx_shift_r[8:1]};
          rx_pos_nxt = rx_pos_r + 4'h1;
          if (rx_pos_r == LAST_M0) begin
            rx_done = 1'b1;
            rx_state_nxt = RX_IDLE;
          end
        end
      end
      default: rx_state_nxt = RX_IDLE;
    endcase
    if (!serial_control_r[SC_REN] ||
        (m0 != rx_state_r[2] && rx_state_r != RX_IDLE)) begin
      rx_state_nxt = RX_IDLE;
      rx_done = 1'b0;
    end
  end

  // acceptance of a finished character and the update of the hold byte
  always_comb begin
    // 8-bit frames leave data in [8:1]; mode 1 ninth slot is the stop
    rx_ninth = (mode == MODE_UART8) ? rxd_in : rx_shift_r[8];
    rx_accept = rx_done && !serial_control_r[SC_RI] &&
      (m0 || !serial_control_r[SC_SM2] || rx_ninth);
    rx_hold_nxt = rx_hold_r;
    if (rx_accept)
      // hold byte is separate from the shifter
      rx_hold_nxt = (m0 || mode == MODE_UART8) ?
        rx_shift_nxt[8:1] : rx_shift_nxt[7:0]; // last m0 bit lands now
  end

  //////////////////////////////////////////////////////////////////////
  // software registers; a hardware set wins over a clear in one cycle

  always_comb begin
    serial_control_nxt = serial_control_r;
    power_control_nxt = power_control_r;
    ie_nxt = ie_r;
    ip_nxt = ip_r;
    if (wr && sel_serial_control) serial_control_nxt = pwdata[7:0];
    if (wr && sel_pc) power_control_nxt = pwdata[7:0] & PC_MASK;
    if (wr && sel_ie) ie_nxt = pwdata[7:0] & IE_MASK;
    if (wr && sel_ip) ip_nxt = pwdata[7:0] & IP_MASK;
    if (tx_done) serial_control_nxt[SC_TI] = 1'b1;
    if (rx_accept) begin
      serial_control_nxt[SC_RI] = 1'b1;
      if (!m0) serial_control_nxt[SC_RB8] = rx_ninth;
    end
    irq_nxt = ie_r[IE_EA] && ie_r[IE_ES] &&
      (serial_control_r[SC_TI] || serial_control_r[SC_RI]);
    irq_high_nxt = ip_r[IP_PS];
  end

  // pins are registered; mode 0 puts the shift clock on txd
  always_comb begin
    txd_nxt = m0 ? ((tx_shifting || rx_m0_active) ? m0_high : 1'b1)
      : tx_line;
    rxd_out_nxt = tx_line;
    rxd_oe_n_nxt = !(m0 && tx_shifting);
  end

  //////////////////////////////////////////////////////////////////////
  // state registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_r <= REG_RESET;
      power_control_r <= REG_RESET;
      ie_r <= REG_RESET;
      ip_r <= REG_RESET;
      rx_hold_r <= REG_RESET;
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      txd_r <= 1'b1;
      rxd_out_r <= 1'b1;
      rxd_oe_n_r <= 1'b1;
      irq_r <= 1'b0;
      irq_high_r <= 1'b0;
      rx_state_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_pos_r <= 4'h0;
      rx_shift_r <= 9'h000;
      rxd_prev_r <= 1'b1;
    end else begin
      serial_control_r <= serial_control_nxt;
      power_control_r <= power_control_nxt;
      ie_r <= ie_nxt;
      ip_r <= ip_nxt;
      rx_hold_r <= rx_hold_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      txd_r <= txd_nxt;
      rxd_out_r <= rxd_out_nxt;
      rxd_oe_n_r <= rxd_oe_n_nxt;
      irq_r <= irq_nxt;
      irq_high_r <= irq_high_nxt;
      rx_state_r <= rx_state_nxt;
      rx_sub_r <= rx_sub_nxt;
      rx_pos_r <= rx_pos_nxt;
      rx_shift_r <= rx_shift_nxt;
      rxd_prev_r <= rxd_in;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign txd = txd_r;
  assign rxd_out = rxd_out_r;
  assign rxd_oe_n = rxd_oe_n_r;
  assign serial_irq = irq_r;
  assign serial_irq_high = irq_high_r;

  //////////////////////////////////////////////////////////////////////
  // checks

  a_ti_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (serial_control_r[SC_TI] && !(wr && sel_serial_control)) |=> serial_control_r[SC_TI])
    else $error("transmit flag cleared without a write");

  a_ri_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (serial_control_r[SC_RI] && !(wr && sel_serial_control)) |=> serial_control_r[SC_RI])
    else $error("receive flag cleared without a write");

  a_irq_gating: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 serial_irq == $past(ie_r[IE_EA] && ie_r[IE_ES] &&
      (serial_control_r[SC_TI] || serial_control_r[SC_RI])))
    else $error("interrupt request does not follow flags");

  a_rx_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_control_r[SC_REN] |=> rx_state_r == RX_IDLE)
    else $error("receiver ran with enable clear");

  a_filter_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_done && !m0 && mode != MODE_UART8 && serial_control_r[SC_SM2] &&
      !rx_shift_r[8] && !serial_control_r[SC_RI] && !(wr && sel_serial_control))
      |=> !serial_control_r[SC_RI])
    else $error("data character passed the filter");

  a_buffer_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && sel_serial_buffer && !pwrite) |=> pready && prdata[7:0] ==
      $past(rx_hold_r))
    else $error("buffer read did not return hold byte");

  a_m0_clock_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (m0 && tx_shifting) |=> txd == $past(m0_high))
    else $error("shift clock missing on txd");
endmodule // serial_port

// ==== tb/serial_far.sv ====
// far-side serial device: async frames and a mode-0 slave
// assumes the bench resolves the rxd pin, which has a pull-up
`timescale 1ns/1ps
module serial_far (
  input wire logic pclk,
  input wire logic txd,
  input wire logic rxd_out,
  output logic rxd
);
  // released line sits at the pull-up level
  initial rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // wait for a txd level, bounded so a dead line cannot hang us
  task automatic wt(input logic lv, output int c);
    c = 0;
    while (txd !== lv && c < 3000) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // start 0, data lsb first, optional ninth, stop 1
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (per) @(posedge pclk);
    end
  endtask

  // find the start fall, then sample every bit at its centre
  task automatic grab(input int n, input int per, output logic [10:0] f);
    int c;
    f = '0;
    wt(1'b0, c);
    repeat (per / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (per) @(posedge pclk);
    end
  endtask

  // mode 0: new bit after each clock fall, tx bit taken at the rise
  task automatic m0(input logic [7:0] b, output logic [7:0] f,
                    output int per);
    int c;
    for (int i = 0; i < 8; i++) begin
      wt(1'b0, c);
      per = c;
      rxd <= b[i];
      wt(1'b1, c);
      per = per + c;
      f[i] = rxd_out;
    end
    // hold the last bit past the sample point before releasing
    repeat (8) @(posedge pclk);
    rxd <= 1'b1;
  endtask
endmodule // serial_far

// ==== tb/tb_top.sv ====
// self-checking bench for the four-mode serial port over APB
// assumes serial_far as the remote device; timers are bench pulses
`timescale 1ns/1ps
module tb_top;
  import serial_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  logic timer1_ovf, timer2_ovf, tsel, rxd_in, rxd_out, rxd_oe_n;
  logic txd, irq, irq_hi, far_rxd;
  logic [1:0] cyc;
  logic [7:0] last_rx, q;
  logic e;
  int fail_count, n_tests;
  logic [7:0] ix [5] = '{IDX_POWER, IDX_SERIAL_CONTROL, IDX_SERIAL_BUFFER, IDX_IE, IDX_IP};
  logic [7:0] mx [3] = '{IDX_POWER, IDX_IE, IDX_IP};
  logic [7:0] mk [3] = '{PC_MASK, IE_MASK, IP_MASK};
  // cases: {mode, rate-double, filter, rx enable, rx ninth, tx ninth}
  // after the address case 0x5E the slave drops its filter for data
  logic [6:0] cs [9] = '{7'h47, 7'h54, 7'h5D, 7'h5E, 7'h54, 7'h53,
                         7'h24, 7'h2C, 7'h67};

  serial_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf),
    .tx_timer2_sel(tsel), .rx_timer2_sel(tsel), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd),
    .serial_irq(irq), .serial_irq_high(irq_hi));
  serial_far i_far (.pclk(pclk), .txd(txd), .rxd_out(rxd_out),
    .rxd(far_rxd));

  // rxd pin: design owns it in mode-0 transmit, else far side
  assign rxd_in = rxd_oe_n ? far_rxd : rxd_out;

  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // overflow pulses: timer1 every 2 clocks, timer2 every 4
  always @(posedge pclk) begin
    cyc <= cyc + 2'h1;
    timer1_ovf <= cyc[0];
    timer2_ovf <= &cyc;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input string nm, input logic [10:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d, checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one APB transfer; an idle edge after it keeps drivers apart
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rq, output logic re);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rq = prdata[7:0];
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rq;
    logic re;
    apb(1'b1, a, d, rq, re);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] rq);
    logic re;
    apb(1'b0, a, 8'h00, rq, re);
  endtask

  // poll serial_control for a flag, bounded by a read count
  task automatic poll(input int b);
    logic [7:0] rq;
    int k;
    k = 0;
    rd(IDX_SERIAL_CONTROL, rq);
    while (rq[b] !== 1'b1 && k < 300) begin
      rd(IDX_SERIAL_CONTROL, rq);
      k++;
    end
  endtask

  // irq is registered one cycle behind its cause
  task automatic irqchk(input logic [1:0] exp);
    @(posedge pclk);
    chk("irq", {irq, irq_hi}, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // mode 0 transfer: transmit with rx off, or receive with rx on
  task automatic m0(input logic ren);
    logic [7:0] d, r, f, rq;
    logic oe;
    int per;
    d = 8'(xs());
    r = 8'(xs());
    wr(IDX_SERIAL_CONTROL, {3'h0, ren, 4'h0});
    if (!ren)
      wr(IDX_SERIAL_BUFFER, d);
    fork
      i_far.m0(r, f, per);
      begin
        // mid-frame: the data pin is driven only while sending
        repeat (40) @(posedge pclk);
        oe = rxd_oe_n;
      end
    join
    poll(ren ? SC_RI : SC_TI);
    chk("m0 period", 11'(per), 11'(M0_DIV));
    chk("rxd drive", oe, ren);
    if (ren) begin
      rd(IDX_SERIAL_BUFFER, rq);
      chk("m0 rx", rq, r);
      last_rx = r;
    end else begin
      chk("m0 tx", f, d);
    end
  endtask

  // async case: transmit and receive at once, then check flags
  task automatic xfer(input logic [6:0] c);
    logic [1:0] md;
    logic rt, sm, rn, nin, tb, ri;
    logic [7:0] d, r, rq;
    logic [10:0] f, rf, ef;
    int n, per;
    {md, rt, sm, rn, nin, tb} = c;
    d = 8'(xs());
    r = 8'(xs());
    per = (md == 2'h2) ? (rt ? 32 : 64) : (md == 2'h1 ? 32 : 64);
    n = (md == 2'h1) ? 10 : 11;
    rf = (md == 2'h1) ? {2'h1, r, 1'b0} : {1'b1, nin, r, 1'b0};
    ef = (md == 2'h1) ? {2'h1, d, 1'b0} : {1'b1, tb, d, 1'b0};
    ri = rn && !(sm && md != 2'h1 && !nin);
    tsel <= (md == 2'h3);
    wr(IDX_POWER, {rt, 7'h00});
    wr(IDX_SERIAL_CONTROL, {md, sm, rn, tb, 3'h0});
    wr(IDX_SERIAL_BUFFER, d);
    fork
      i_far.grab(n, per, f);
      i_far.send(rf, n, per);
    join
    poll(SC_TI);
    rd(IDX_SERIAL_CONTROL, rq);
    chk("serial_control", rq, {md, sm, rn, tb, rn & (md == 2'h1 | nin), 1'b1, ri});
    chk("tx frame", f, ef);
    if (ri)
      last_rx = r;
    rd(IDX_SERIAL_BUFFER, rq);
    chk("rx buffer", rq, last_rx);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rs = 32'h000010B8;
    cyc = 2'h0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tsel = 1'b0;
    timer1_ovf = 1'b0;
    timer2_ovf = 1'b0;
    fail_count = 0;
    n_tests = 0;
    last_rx = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ix[i]) begin
      rd(ix[i], q);
      chk("reset value", q, REG_RESET);
    end
    apb(1'b0, 8'h10, 8'h00, q, e);
    chk("unmapped", {e, q}, 11'h100);
    // low three power bits stay zero in every write
    foreach (mx[i]) begin
      wr(mx[i], 8'hF8);
      rd(mx[i], q);
      chk("write mask", q, mk[i] & 8'hF8);
      wr(mx[i], 8'h00);
    end
    m0(1'b0);
    m0(1'b1);
    foreach (cs[i])
      xfer(cs[i]);
    // transmit flag is still set from the last case
    wr(IDX_IP, 8'h10);
    wr(IDX_IE, 8'h90);
    irqchk(2'h3);
    wr(IDX_SERIAL_CONTROL, 8'h00);
    irqchk(2'h1);
    wr(IDX_SERIAL_CONTROL, 8'h01);
    irqchk(2'h3);
    wr(IDX_IE, 8'h10);
    irqchk(2'h1);
    complete_run();
  end

  // watchdog: the full run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    complete_run();
  end
endmodule // tb_top
